/* src/pll_lock_and_bandwidth_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_defs.svh"
// Overview of operation
// - oscillator clock and buffered loop reference copy
// - reference clock copy goes to timebase
// - reference divided by programmable R
// - feedback is VCO over N times 2^P
// - centre setting is L times 2^E times 125k
// - phase detector emits up/down correction pulses
// - lock detector compares feedback and reference frequency
// - tracking bit clear means acquisition mode
// - auto mode switches filter mode itself
// - auto tracking bit read-only, follows tolerance
// - auto settled flag read-only, follows tolerance
// - enabled interrupt on every settled flag toggle
// - manual mode tracking bit writable, drives filter
// - manual mode: no settled flag, no interrupt
// - manual mode forces irq enable clear
// - manual mode event and settled flags read clear
// - source select cleared if off or range zero
// - source select forces power on
module pll_lock_and_bandwidth_control #(
  parameter logic [7:0]  WINDOW_REFS = `LOCK_WINDOW,
  parameter logic [11:0] ACQ_TOL     = `ACQ_TOL,
  parameter logic [11:0] LOCK_TOL    = `LOCK_TOL
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        crystal_in,
  input  wire logic        vco_clock,
  output logic             osc_clock,
  output logic             loop_ref_clock,
  output logic             timebase_ref_clock,
  output logic             divided_ref_clock,
  output logic             prescaled_vco_clock,
  output logic             feedback_clock,
  output logic             correction_up,
  output logic             correction_down,
  output logic             filter_tracking_bit,
  output logic             freq_settled,
  output logic             loop_power_on,
  output logic             base_source_select,
  output logic [17:0]      vco_centre_khz,
  output logic             loop_irq
);
  pll_pkg::ctrl_type        ctrl_reg, ctrl_next;
  pll_pkg::filter_mode_type det_mode_reg, det_mode_next;
  logic        auto_reg, auto_next;
  logic        man_track_reg, man_track_next;
  logic [11:0] mul_reg, mul_next;
  logic [7:0]  range_reg, range_next;
  logic [3:0]  refdiv_reg, refdiv_next;
  logic        aw_full_reg, aw_full_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        w_full_reg, w_full_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        xin_q_reg, vco_q_reg;
  logic        osc_reg, ref_reg, tb_reg;
  logic [3:0]  r_cnt_reg, r_cnt_next;
  logic [2:0]  p_cnt_reg, p_cnt_next;
  logic [11:0] n_cnt_reg, n_cnt_next;
  logic        ref_pulse_reg, ref_pulse_next;
  logic        pclk_reg, pclk_next;
  logic        fb_pulse_reg, fb_pulse_next;
  logic        up_reg, up_next;
  logic        dn_reg, dn_next;
  logic [7:0]  win_cnt_reg, win_cnt_next;
  logic [11:0] fb_cnt_reg, fb_cnt_next;
  logic        lock_reg, lock_next;
  logic [17:0] centre_reg, centre_next;
  logic        ref_edge, vco_edge, p_last, do_write;
  logic [3:0]  r_eff;
  logic [11:0] n_eff, fb_total, fb_err, win12;
  logic [7:0]  wr_addr, wd;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;

  assign ref_edge = crystal_in & ~xin_q_reg;
  assign vco_edge = vco_clock & ~vco_q_reg;
  // zero divider values behave as one
  assign r_eff    = (refdiv_reg == 4'h0) ? 4'h1 : refdiv_reg;
  assign n_eff    = (mul_reg == 12'h000) ? 12'h001 : mul_reg;
  assign p_last   = ({1'b0, p_cnt_reg} == ((4'h1 << ctrl_reg.prescale_sel) - 4'h1));
  assign win12    = {4'h0, WINDOW_REFS};
  assign fb_total = (fb_cnt_reg == 12'hfff) ? fb_cnt_reg : fb_cnt_reg + {11'h000, fb_pulse_reg};
  assign fb_err   = (fb_total >= win12) ? fb_total - win12 : win12 - fb_total;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_addr  = {aw_addr_reg[7:2], 2'b00};
  assign wd       = w_data_reg[7:0];

  always_comb begin
    rd_resp = `RESP_OKAY;
    rd_data = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `CTRL_OFS: rd_data[7:0] = {ctrl_reg.loop_event_irq_enable,
                                 ctrl_reg.loop_event_flag & auto_reg,
                                 ctrl_reg.loop_power_on, ctrl_reg.base_source_select,
                                 ctrl_reg.prescale_sel, ctrl_reg.vco_range_exp};
      `BW_OFS: rd_data[7:0] = {auto_reg, lock_reg & auto_reg, filter_tracking_bit, 5'h00};
      `MUL_OFS: rd_data[11:0] = mul_reg;
      `RANGE_OFS: rd_data[7:0] = range_reg;
      `REFDIV_OFS: rd_data[3:0] = refdiv_reg;
      default: rd_resp = `RESP_SLVERR;
    endcase
  end

  always_comb begin
    ctrl_next      = ctrl_reg;
    auto_next      = auto_reg;
    man_track_next = man_track_reg;
    mul_next       = mul_reg;
    range_next     = range_reg;
    refdiv_next    = refdiv_reg;
    aw_full_next   = aw_full_reg;
    aw_addr_next   = aw_addr_reg;
    w_full_next    = w_full_reg;
    w_data_next    = w_data_reg;
    w_strb_next    = w_strb_reg;
    bvalid_next    = bvalid_reg & ~s_axi_bready;
    bresp_next     = bresp_reg;
    rvalid_next    = rvalid_reg & ~s_axi_rready;
    rdata_next     = rdata_reg;
    rresp_next     = rresp_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_data;
      rresp_next  = rd_resp;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RESP_OKAY;
      unique case (wr_addr)
        `CTRL_OFS: if (w_strb_reg[0]) begin
          ctrl_next.loop_event_irq_enable = wd[7];
          if (wd[`CTRL_FLAG_BIT]) ctrl_next.loop_event_flag = 1'b0;
          ctrl_next.loop_power_on = wd[5] | ctrl_reg.base_source_select;
          // selecting needs the loop already on: no simultaneous on and select
          ctrl_next.base_source_select = wd[4] & ctrl_reg.loop_power_on;
          if (!ctrl_reg.loop_power_on) begin
            ctrl_next.prescale_sel  = wd[3:2];
            ctrl_next.vco_range_exp = wd[1:0];
          end
        end
        `BW_OFS: if (w_strb_reg[0]) begin
          auto_next = wd[`BW_AUTO_BIT];
          if (!wd[`BW_AUTO_BIT]) man_track_next = wd[`BW_TRACK_BIT];
        end
        `MUL_OFS: if (!ctrl_reg.loop_power_on) begin
          if (w_strb_reg[0]) mul_next[7:0] = wd;
          if (w_strb_reg[1]) mul_next[11:8] = w_data_reg[11:8];
        end
        `RANGE_OFS: if (!ctrl_reg.loop_power_on && w_strb_reg[0]) range_next = wd;
        `REFDIV_OFS: if (!ctrl_reg.loop_power_on && w_strb_reg[0]) refdiv_next = wd[3:0];
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    ctrl_next.base_source_select = ctrl_next.base_source_select & ctrl_next.loop_power_on
                                   & (range_next != 8'h00);
    ctrl_next.loop_event_irq_enable = ctrl_next.loop_event_irq_enable & auto_next;
  end

  always_comb begin
    r_cnt_next     = r_cnt_reg;
    p_cnt_next     = p_cnt_reg;
    n_cnt_next     = n_cnt_reg;
    ref_pulse_next = 1'b0;
    pclk_next      = 1'b0;
    fb_pulse_next  = 1'b0;
    win_cnt_next   = win_cnt_reg;
    fb_cnt_next    = fb_total;
    det_mode_next  = det_mode_reg;
    lock_next      = lock_reg;
    up_next        = up_reg | ref_pulse_reg;
    dn_next        = dn_reg | fb_pulse_reg;
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    if (ref_edge) begin
      r_cnt_next     = (r_cnt_reg >= r_eff - 4'h1) ? 4'h0 : r_cnt_reg + 4'h1;
      ref_pulse_next = (r_cnt_reg >= r_eff - 4'h1);
    end
    if (vco_edge) begin
      p_cnt_next = p_last ? 3'h0 : p_cnt_reg + 3'h1;
      pclk_next  = p_last;
      if (p_last) begin
        n_cnt_next    = (n_cnt_reg >= n_eff - 12'h001) ? 12'h000 : n_cnt_reg + 12'h001;
        fb_pulse_next = (n_cnt_reg >= n_eff - 12'h001);
      end
    end
    if (ref_pulse_reg) begin
      if (win_cnt_reg >= WINDOW_REFS - 8'h01) begin
        win_cnt_next  = 8'h00;
        fb_cnt_next   = 12'h000;
        det_mode_next = (fb_err <= ACQ_TOL) ? pll_pkg::filter_tracking
                                            : pll_pkg::filter_acquisition;
        lock_next     = (fb_err <= LOCK_TOL);
      end else begin
        win_cnt_next = win_cnt_reg + 8'h01;
      end
    end
    if (!ctrl_reg.loop_power_on) begin
      r_cnt_next     = 4'h0;
      p_cnt_next     = 3'h0;
      n_cnt_next     = 12'h000;
      ref_pulse_next = 1'b0;
      pclk_next      = 1'b0;
      fb_pulse_next  = 1'b0;
      up_next        = 1'b0;
      dn_next        = 1'b0;
      win_cnt_next   = 8'h00;
      fb_cnt_next    = 12'h000;
    end
    if (!ctrl_reg.loop_power_on || !auto_reg) begin
      det_mode_next = pll_pkg::filter_acquisition;
      lock_next     = 1'b0;
    end
    centre_next = 18'(({10'h000, range_reg} << ctrl_reg.vco_range_exp) * `VCO_NOM_KHZ);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg      <= `CTRL_RESET;
      auto_reg      <= 1'b0;
      man_track_reg <= 1'b0;
      mul_reg       <= `MUL_RESET;
      range_reg     <= `RANGE_RESET;
      refdiv_reg    <= `REFDIV_RESET;
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_full_reg    <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `RESP_OKAY;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      rresp_reg     <= `RESP_OKAY;
      xin_q_reg     <= 1'b0;
      vco_q_reg     <= 1'b0;
      osc_reg       <= 1'b0;
      ref_reg       <= 1'b0;
      tb_reg        <= 1'b0;
      r_cnt_reg     <= 4'h0;
      p_cnt_reg     <= 3'h0;
      n_cnt_reg     <= 12'h000;
      ref_pulse_reg <= 1'b0;
      pclk_reg      <= 1'b0;
      fb_pulse_reg  <= 1'b0;
      up_reg        <= 1'b0;
      dn_reg        <= 1'b0;
      win_cnt_reg   <= 8'h00;
      fb_cnt_reg    <= 12'h000;
      det_mode_reg  <= pll_pkg::filter_acquisition;
      lock_reg      <= 1'b0;
      centre_reg    <= 18'h00000;
    end else begin
      ctrl_reg      <= ctrl_next;
      // event flag: a lock change in the clearing cycle wins over the clear
      if (auto_reg && auto_next && (lock_next != lock_reg))
        ctrl_reg.loop_event_flag <= 1'b1;
      if (!auto_next) ctrl_reg.loop_event_flag <= 1'b0;
      auto_reg      <= auto_next;
      man_track_reg <= man_track_next;
      mul_reg       <= mul_next;
      range_reg     <= range_next;
      refdiv_reg    <= refdiv_next;
      aw_full_reg   <= aw_full_next;
      aw_addr_reg   <= aw_addr_next;
      w_full_reg    <= w_full_next;
      w_data_reg    <= w_data_next;
      w_strb_reg    <= w_strb_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
      xin_q_reg     <= crystal_in;
      vco_q_reg     <= vco_clock;
      osc_reg       <= crystal_in;
      ref_reg       <= crystal_in;
      tb_reg        <= crystal_in;
      r_cnt_reg     <= r_cnt_next;
      p_cnt_reg     <= p_cnt_next;
      n_cnt_reg     <= n_cnt_next;
      ref_pulse_reg <= ref_pulse_next;
      pclk_reg      <= pclk_next;
      fb_pulse_reg  <= fb_pulse_next;
      up_reg        <= up_next;
      dn_reg        <= dn_next;
      win_cnt_reg   <= win_cnt_next;
      fb_cnt_reg    <= fb_cnt_next;
      det_mode_reg  <= det_mode_next;
      lock_reg      <= lock_next;
      centre_reg    <= centre_next;
    end
  end

  assign s_axi_awready       = ~aw_full_reg;
  assign s_axi_wready        = ~w_full_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = ~rvalid_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign osc_clock           = osc_reg;
  assign loop_ref_clock      = ref_reg;
  assign timebase_ref_clock  = tb_reg;
  assign divided_ref_clock   = ref_pulse_reg;
  assign prescaled_vco_clock = pclk_reg;
  assign feedback_clock      = fb_pulse_reg;
  assign correction_up       = up_reg;
  assign correction_down     = dn_reg;
  assign filter_tracking_bit = auto_reg ? (det_mode_reg == pll_pkg::filter_tracking)
                                        : man_track_reg;
  assign freq_settled        = lock_reg & auto_reg;
  assign loop_power_on       = ctrl_reg.loop_power_on;
  assign base_source_select  = ctrl_reg.base_source_select;
  assign vco_centre_khz      = centre_reg;
  assign loop_irq            = ctrl_reg.loop_event_flag & ctrl_reg.loop_event_irq_enable
                               & auto_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_select_needs_on;
    base_source_select |-> loop_power_on && (range_reg != 8'h00);
  endproperty
  a_select_needs_on: assert property (p_select_needs_on) else $error("select without loop");
  property p_on_held;
    $past(base_source_select) |-> loop_power_on;
  endproperty
  a_on_held: assert property (p_on_held) else $error("loop off while selected");
  property p_irq_en_manual;
    !auto_reg |-> !ctrl_reg.loop_event_irq_enable;
  endproperty
  a_irq_en_manual: assert property (p_irq_en_manual) else $error("irq enable in manual");
  property p_manual_quiet;
    !auto_reg |-> !loop_irq && !freq_settled && !ctrl_reg.loop_event_flag;
  endproperty
  a_manual_quiet: assert property (p_manual_quiet) else $error("manual irq or settle");
  property p_event_on_toggle;
    ($changed(lock_reg) && auto_reg && $past(auto_reg)) |-> ctrl_reg.loop_event_flag;
  endproperty
  a_event_on_toggle: assert property (p_event_on_toggle) else $error("toggle lost");
  property p_ref_div;
    divided_ref_clock |-> $past(ref_edge) && !$past(divided_ref_clock) || (r_eff == 4'h1);
  endproperty
  a_ref_div: assert property (p_ref_div) else $error("bad ref pulse");
  property p_fb_from_vco;
    feedback_clock |-> $past(vco_edge) && prescaled_vco_clock;
  endproperty
  a_fb_from_vco: assert property (p_fb_from_vco) else $error("bad fb pulse");
  property p_phase;
    !(correction_up && correction_down) and
    (loop_power_on && divided_ref_clock && !feedback_clock && !correction_down
     |=> correction_up);
  endproperty
  a_phase: assert property (p_phase) else $error("phase detector wrong");
  property p_manual_track;
    (do_write && wr_addr == `BW_OFS && w_strb_reg[0] && !wd[`BW_AUTO_BIT])
      |=> filter_tracking_bit == $past(wd[`BW_TRACK_BIT]);
  endproperty
  a_manual_track: assert property (p_manual_track) else $error("manual mode ignored");
  property p_window_track;
    (auto_reg && ctrl_reg.loop_power_on && ref_pulse_reg && win_cnt_reg == WINDOW_REFS - 8'h01
     && fb_err <= LOCK_TOL) ##1 auto_reg |-> freq_settled && filter_tracking_bit;
  endproperty
  a_window_track: assert property (p_window_track) else $error("lock not taken");
  c_lock: cover property ($rose(freq_settled));
  c_irq: cover property ($rose(loop_irq));
  c_select: cover property ($rose(base_source_select));
endmodule : pll_lock_and_bandwidth_control
`default_nettype wire

/* include/pll_defs.svh */
`ifndef PLL_DEFS_SVH
`define PLL_DEFS_SVH
`define CTRL_OFS      8'h00
`define BW_OFS        8'h04
`define MUL_OFS       8'h08
`define RANGE_OFS     8'h0c
`define REFDIV_OFS    8'h10
`define CTRL_RESET    8'h20
`define MUL_RESET     12'h040
`define RANGE_RESET   8'h40
`define REFDIV_RESET  4'h1
`define BW_AUTO_BIT   7
`define BW_LOCK_BIT   6
`define BW_TRACK_BIT  5
`define CTRL_FLAG_BIT 6
// nominal centre-of-range frequency, 125 kHz
`define VCO_NOM_KHZ   18'h0007d
`define LOCK_WINDOW   8'h10
`define ACQ_TOL       12'h002
`define LOCK_TOL      12'h001
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

/* include/pll_pkg.sv */
package pll_pkg;
  typedef struct packed {
    logic       loop_event_irq_enable;
    logic       loop_event_flag;
    logic       loop_power_on;
    logic       base_source_select;
    logic [1:0] prescale_sel;
    logic [1:0] vco_range_exp;
  } ctrl_type;
  typedef enum logic {filter_acquisition, filter_tracking} filter_mode_type;
endpackage : pll_pkg

/* testbench/pll_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pll_partner #(
  parameter int XTAL_HALF = 8
) (
  input  wire logic       clock,
  input  wire logic [7:0] vco_half,
  output logic            crystal_in,
  output logic            vco_clock
);
  int xtal_count;
  int vco_count;
  initial begin
    crystal_in = 1'b0;
    vco_clock = 1'b0;
    xtal_count = 0;
    vco_count = 0;
  end
  // free-running external reference, brought into range by the reference divider
  always @(posedge clock) begin
    xtal_count <= (xtal_count >= XTAL_HALF - 1) ? 0 : xtal_count + 1;
    if (xtal_count >= XTAL_HALF - 1) crystal_in <= ~crystal_in;
  end
  // oscillator whose half period stands for the filter capacitor voltage
  always @(posedge clock) begin
    vco_count <= (vco_count >= int'(vco_half) - 1) ? 0 : vco_count + 1;
    if (vco_count >= int'(vco_half) - 1) vco_clock <= ~vco_clock;
  end
endmodule : pll_partner
`default_nettype wire

/* testbench/test_pll_lock_and_bandwidth_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pll_lock_and_bandwidth_control;
  localparam int XH = 8;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} row_type;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [7:0]  vco_half = 8'h06;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, crystal_in, vco_clock;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic        osc, lref, tbref, dref, pvco, fb, trk, settled, pon, sel, irq, prev, up, dn, pd;
  logic [17:0] centre;
  int          err_total = 0;
  int          checked = 0;
  int          nd, np, nf, bad, nu, nb;
  row_type     rows[22];

  pll_lock_and_bandwidth_control dut_u (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .crystal_in(crystal_in), .vco_clock(vco_clock), .osc_clock(osc), .loop_ref_clock(lref),
    .timebase_ref_clock(tbref), .divided_ref_clock(dref), .prescaled_vco_clock(pvco),
    .feedback_clock(fb), .correction_up(up), .correction_down(dn), .filter_tracking_bit(trk),
    .freq_settled(settled), .loop_power_on(pon), .base_source_select(sel),
    .vco_centre_khz(centre), .loop_irq(irq));
  pll_partner #(.XTAL_HALF(XH)) partner_u (
    .clock(clock), .vco_half(vco_half), .crystal_in(crystal_in), .vco_clock(vco_clock));

  always #10 clock = ~clock;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic check(input string n, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : check

  task automatic timeout();
    err_total++;
    $display("mismatch wait expected done seen timeout");
    test_done();
  endtask : timeout

  task automatic bus_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 50) timeout();
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 50) timeout();
  endtask : bus_read

  task automatic put(input logic [7:0] a, input logic [31:0] v);
    bus_write(a, v, r);
    check("bresp", 32'h0, {30'h0, r});
  endtask : put

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] x);
    bus_read(a, d, r);
    check("rdata", x, d);
  endtask : expect_reg

  task automatic wait_settled(input logic v);
    int n;
    for (n = 0; n < 4000 && settled !== v; n++) @(posedge clock);
    if (n == 4000) timeout();
  endtask : wait_settled

  task automatic do_reset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
  endtask : do_reset

  initial begin
    do_reset();
    rows = '{'{1'b0, 8'h00, 32'h00, 32'h20, 2'h0},
             '{1'b0, 8'h04, 32'h00, 32'h00, 2'h0},
             '{1'b0, 8'h08, 32'h00, 32'h40, 2'h0},
             '{1'b0, 8'h0c, 32'h00, 32'h40, 2'h0},
             '{1'b0, 8'h10, 32'h00, 32'h01, 2'h0},
             '{1'b1, 8'h14, 32'h05, 32'h00, 2'h2},
             '{1'b1, 8'h04, 32'h20, 32'h20, 2'h0},
             '{1'b1, 8'h04, 32'h00, 32'h00, 2'h0},
             '{1'b1, 8'h00, 32'he0, 32'h20, 2'h0},
             '{1'b1, 8'h00, 32'h00, 32'h00, 2'h0},
             '{1'b1, 8'h00, 32'h30, 32'h20, 2'h0},
             '{1'b1, 8'h00, 32'h00, 32'h00, 2'h0},
             '{1'b1, 8'h0c, 32'h00, 32'h00, 2'h0},
             '{1'b1, 8'h00, 32'h20, 32'h20, 2'h0},
             '{1'b1, 8'h00, 32'h30, 32'h20, 2'h0},
             '{1'b1, 8'h00, 32'h00, 32'h00, 2'h0},
             '{1'b1, 8'h08, 32'h02, 32'h02, 2'h0},
             '{1'b1, 8'h0c, 32'h60, 32'h60, 2'h0},
             '{1'b1, 8'h10, 32'h03, 32'h03, 2'h0},
             '{1'b1, 8'h00, 32'h06, 32'h06, 2'h0},
             '{1'b1, 8'h00, 32'h26, 32'h26, 2'h0},
             '{1'b1, 8'h08, 32'h07, 32'h02, 2'h0}};
    foreach (rows[i]) begin
      if (rows[i].w) begin
        bus_write(rows[i].a, rows[i].d, r);
        check("bresp", {30'h0, rows[i].r}, {30'h0, r});
      end
      bus_read(rows[i].a, d, r);
      check("rresp", {30'h0, rows[i].r}, {30'h0, r});
      check("rdata", rows[i].x, d);
      $display("row %0d done", i);
    end
    check("centre", 32'h0000bb80, {14'h0, centre});
    nd = 0;
    np = 0;
    nf = 0;
    bad = 0;
    nu = 0;
    nb = 0;
    pd = 1'b0;
    prev = crystal_in;
    repeat (480) begin
      @(posedge clock);
      nd += (dref === 1'b1);
      np += (pvco === 1'b1);
      nf += (fb === 1'b1);
      bad += (osc !== prev || lref !== osc || tbref !== osc);
      // a reference pulse with no feedback pending must raise up next cycle
      nu += (pd && up !== 1'b1);
      nb += (up === 1'b1 && dn === 1'b1);
      pd = (dref === 1'b1 && fb !== 1'b1 && dn !== 1'b1);
      prev = crystal_in;
    end
    check("copies", 0, bad);
    check("up correction", 0, nu);
    check("both corrections", 0, nb);
    check("ref pulses", 32'(480 / (2 * XH * 3)), nd);
    check("prescaled", 32'(480 / (2 * 6 * 2)), np);
    check("feedback", 32'(480 / (2 * 6 * 2 * 2)), nf);
    $display("divider test done");
    put(8'h04, 32'h20);
    check("tracking", 1, {31'h0, trk});
    put(8'h04, 32'h80);
    wait_settled(1'b1);
    check("tracking", 1, {31'h0, trk});
    expect_reg(8'h04, 32'he0);
    expect_reg(8'h00, 32'h66);
    put(8'h00, 32'h36);
    check("select", 1, {31'h0, sel});
    put(8'h00, 32'h16);
    expect_reg(8'h00, 32'h76);
    check("power", 1, {31'h0, pon});
    put(8'h00, 32'ha6);
    check("irq", 1, {31'h0, irq});
    put(8'h00, 32'he6);
    check("irq", 0, {31'h0, irq});
    expect_reg(8'h00, 32'ha6);
    $display("lock test done");
    vco_half <= 8'h03;
    wait_settled(1'b0);
    check("tracking", 0, {31'h0, trk});
    check("irq", 1, {31'h0, irq});
    expect_reg(8'h04, 32'h80);
    put(8'h04, 32'h00);
    check("irq", 0, {31'h0, irq});
    expect_reg(8'h00, 32'h26);
    $display("unlock test done");
    do_reset();
    @(posedge clock);
    check("reset", 32'h8, {28'h0, pon, sel, trk, irq});
    $display("reset test done");
    test_done();
  end
endmodule : test_pll_lock_and_bandwidth_control
`default_nettype wire
